// >>> rtl/encoder_compare_counter.sv
// Encoder compare stage and count register with an AXI4-Lite slave
// Operation
// - Encoder mode, compare on: count equal to low 16 compare bits sets flag
// - Encoder mode with Z: interrupt request withheld until Z detected
// - Event-count mode, compare on: low 16 bits match sets flag, Z ignored
// - Flag set and interrupt enable one gives request; else flag only
// - Timer-count mode: time counter equal to 24-bit value sets flag
// - Timer mode: internal counter equal to 24-bit value sets flag
// - Upper eight compare bits used only in timer-count and timer modes
// - Eight modes from two-bit mode field, Z enable, three-phase enable
`timescale 1ns/1ps
module encoder_compare_counter
  import enc_cmp_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic [STRB_W-1:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [DATA_W-1:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Encoder pins
  input wire pin_t enc_pins,
  // Interrupts
  output logic encoder_irq_request,
  output logic irq
);
  ctrl_t ctrl_reg;
  logic [STAT_W-1:0] status_reg;
  logic [STAT_W-1:0] status_next;
  logic [STAT_W-1:0] mask_reg;
  logic [CNT_W-1:0] position_compare_value;
  logic [CNT_W-1:0] count_value_field;
  logic count_chg_reg;
  logic [ADDR_W-1:0] aw_addr_reg;
  logic [DATA_W-1:0] w_data_reg;
  logic [STRB_W-1:0] w_strb_reg;
  logic wr_go;
  logic [DATA_W-1:0] wr_val;
  logic [STAT_W-1:0] stat_set;
  logic [STAT_W-1:0] stat_clr;
  logic hit;
  logic irq_gate;
  op_mode_t op_mode;
  pin_t pin_lvl;
  pin_t pin_rise;

  // Byte-lane merge of a write into an old register value
  function automatic logic [DATA_W-1:0] merge(
    input logic [DATA_W-1:0] old_v,
    input logic [DATA_W-1:0] new_v,
    input logic [STRB_W-1:0] strb
  );
    logic [DATA_W-1:0] r;
    r = old_v;
    for (int i = 0; i < STRB_W; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // Mode decode from the control bits
  function automatic op_mode_t decode(input ctrl_t c);
    case (c.mode)
      MODE_ENCODER: return c.zen ? OP_ENC_Z : OP_ENC;
      MODE_EVENT: return c.three_phase_enable ? OP_EVT3 : OP_EVT2;
      MODE_TIMECNT: return c.three_phase_enable ? OP_TCNT3 : OP_TCNT2;
      default: return c.zen ? OP_TMR_Z : OP_TMR;
    endcase
  endfunction

  // Timer-type modes use all 24 bits
  function automatic logic wide_mode(input op_mode_t m);
    return m == OP_TCNT2 || m == OP_TCNT3 || m == OP_TMR || m == OP_TMR_Z;
  endfunction

  // Pin synchronisers, one per encoder pin
  generate
    for (genvar g = 0; g < PIN_N; g++) begin : g_sync
      pin_sync_edge u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .pin_in(enc_pins[g]),
        .level(pin_lvl[g]),
        .rise(pin_rise[g])
      );
    end
  endgenerate

  assign op_mode = decode(ctrl_reg);

  // Write channel: address and data taken in either order
  assign wr_go = !awready && !wready && !bvalid;
  assign wr_val = merge(DATA_W'(0), w_data_reg, w_strb_reg);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b1;
      aw_addr_reg <= '0;
    end else if (awvalid && awready) begin
      awready <= 1'b0;
      aw_addr_reg <= awaddr;
    end else if (bvalid && bready) begin
      awready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wready <= 1'b1;
      w_data_reg <= '0;
      w_strb_reg <= '0;
    end else if (wvalid && wready) begin
      wready <= 1'b0;
      w_data_reg <= wdata;
      w_strb_reg <= wstrb;
    end else if (bvalid && bready) begin
      wready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else if (wr_go) begin
      bvalid <= 1'b1;
      case (aw_addr_reg)
        CTRL_OFS, STAT_OFS, MASK_OFS, CMPV_OFS, CNT_OFS: bresp <= RESP_OKAY;
        default: bresp <= RESP_SLVERR;
      endcase
    end else if (bvalid && bready) begin
      bvalid <= 1'b0;
    end
  end

  // Control, mask and compare registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= '0;
      mask_reg <= STAT_RESET;
      position_compare_value <= CMPV_RESET;
    end else if (wr_go) begin
      case (aw_addr_reg)
        CTRL_OFS: ctrl_reg <= ctrl_t'(CTRL_W'(merge(DATA_W'(ctrl_reg),
                                    w_data_reg, w_strb_reg)));
        MASK_OFS: mask_reg <= STAT_W'(merge(DATA_W'(mask_reg), w_data_reg,
                                    w_strb_reg));
        // Upper byte dropped on write
        CMPV_OFS: position_compare_value <= CNT_W'(merge(
          DATA_W'(position_compare_value), w_data_reg,
          w_strb_reg));
        default: ;
      endcase
    end
  end

  // Counter: encoder pulses or internal time, per mode
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_value_field <= CNT_RESET;
      count_chg_reg <= 1'b0;
    end else begin
      count_chg_reg <= 1'b0;
      if (wr_go && aw_addr_reg == CNT_OFS) begin
        count_value_field <= CNT_W'(merge(DATA_W'(count_value_field),
                                   w_data_reg, w_strb_reg));
      end else if (ctrl_reg.run) begin
        case (op_mode)
          OP_ENC, OP_ENC_Z: begin
            if (pin_rise.pulse) begin
              count_chg_reg <= 1'b1;
              count_value_field <= {8'h00, pin_lvl.dir ?
                count_value_field[LOW_W-1:0] + LOW_STEP :
                count_value_field[LOW_W-1:0] - LOW_STEP};
            end
          end
          OP_EVT2, OP_EVT3: begin
            if (pin_rise.pulse) begin
              count_chg_reg <= 1'b1;
              count_value_field <= {8'h00,
                count_value_field[LOW_W-1:0] + LOW_STEP};
            end
          end
          OP_TCNT2, OP_TCNT3: begin
            // Time since the last pulse; a long gap is an error
            count_chg_reg <= 1'b1;
            count_value_field <= pin_rise.pulse ? CNT_RESET :
                                 count_value_field + CNT_STEP;
          end
          OP_TMR_Z: begin
            count_chg_reg <= 1'b1;
            count_value_field <= pin_rise.z ? CNT_RESET :
                                 count_value_field + CNT_STEP;
          end
          OP_TMR: begin
            count_chg_reg <= 1'b1;
            count_value_field <= count_value_field + CNT_STEP;
          end
          default: ;
        endcase
      end
    end
  end

  // Match check after each counter update
  assign hit = wide_mode(op_mode) ?
    count_value_field == position_compare_value :
    count_value_field[LOW_W-1:0] ==
      position_compare_value[LOW_W-1:0];

  // Set wins over a write-one clear in the same cycle
  always_comb begin
    stat_set = '0;
    stat_set[STAT_CMP] = ctrl_reg.run && ctrl_reg.cmpen && count_chg_reg &&
                         hit;
    stat_set[STAT_ZDET] = ctrl_reg.run && pin_rise.z;
    stat_clr = (wr_go && aw_addr_reg == STAT_OFS) ?
               wr_val[STAT_W-1:0] : '0;
    status_next = ctrl_reg.run ? ((status_reg & ~stat_clr) | stat_set) :
                  STAT_RESET;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_reg <= STAT_RESET;
    end else begin
      status_reg <= status_next;
    end
  end

  // Z-gated mode holds the request off until Z is seen
  assign irq_gate = op_mode != OP_ENC_Z || status_reg[STAT_ZDET];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      encoder_irq_request <= 1'b0;
      irq <= 1'b0;
    end else begin
      encoder_irq_request <= status_reg[STAT_CMP] && ctrl_reg.inten &&
                             irq_gate;
      irq <= |(status_reg & mask_reg);
    end
  end

  // Read channel, no side effects on read
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rresp <= RESP_OKAY;
      case (araddr)
        CTRL_OFS: rdata <= DATA_W'(ctrl_reg);
        STAT_OFS: rdata <= DATA_W'(status_reg);
        MASK_OFS: rdata <= DATA_W'(mask_reg);
        CMPV_OFS: rdata <= DATA_W'(position_compare_value);
        CNT_OFS: rdata <= DATA_W'(count_value_field);
        default: begin
          rdata <= '0;
          rresp <= RESP_SLVERR;
        end
      endcase
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_enc_low_match: assert property (
    (op_mode == OP_ENC && ctrl_reg.run && ctrl_reg.cmpen && count_chg_reg
     && count_value_field[LOW_W-1:0] == position_compare_value[LOW_W-1:0])
    |=> status_reg[STAT_CMP])
    else $error("encoder match did not set compare flag");

  a_zgate_hold: assert property (
    (op_mode == OP_ENC_Z && !status_reg[STAT_ZDET])
    |=> !encoder_irq_request)
    else $error("request raised before Z detection");

  a_event_match: assert property (
    ((op_mode == OP_EVT2 || op_mode == OP_EVT3) && ctrl_reg.run &&
     ctrl_reg.cmpen && count_chg_reg &&
     count_value_field[LOW_W-1:0] == position_compare_value[LOW_W-1:0])
    |=> status_reg[STAT_CMP])
    else $error("event count match missed");

  a_irq_follows: assert property (
    ##1 encoder_irq_request == $past(status_reg[STAT_CMP] &&
      ctrl_reg.inten && irq_gate))
    else $error("request does not follow flag and enable");

  a_timecnt_match: assert property (
    ((op_mode == OP_TCNT2 || op_mode == OP_TCNT3) && ctrl_reg.run &&
     ctrl_reg.cmpen && count_chg_reg &&
     count_value_field == position_compare_value)
    |=> status_reg[STAT_CMP])
    else $error("time error not flagged");

  a_timer_match: assert property (
    ((op_mode == OP_TMR || op_mode == OP_TMR_Z) && ctrl_reg.run &&
     ctrl_reg.cmpen && count_chg_reg &&
     count_value_field == position_compare_value)
    |=> status_reg[STAT_CMP])
    else $error("timer match not flagged");

  a_no_wide_hit: assert property (
    (!wide_mode(op_mode) && count_chg_reg && count_value_field[LOW_W-1:0]
     != position_compare_value[LOW_W-1:0] && !status_reg[STAT_CMP])
    |=> !status_reg[STAT_CMP])
    else $error("flag set without low-bit match");

  a_mode_decode: assert property (
    (ctrl_reg.mode == MODE_TIMER && ctrl_reg.zen) |-> op_mode == OP_TMR_Z)
    else $error("mode decode wrong");

  a_upper_zero: assert property (
    $rose(rvalid) |-> rdata[DATA_W-1:CNT_W] == '0)
    else $error("upper read bits not zero");
endmodule // encoder_compare_counter

// >>> rtl/pin_sync_edge.sv
// Two-stage synchroniser with rising edge detect for one pin
`timescale 1ns/1ps
module pin_sync_edge (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Pin and synchronised result
  input wire logic pin_in,
  output logic level,
  output logic rise
);
  logic meta_reg;
  logic sync_reg;
  logic prev_reg;

  // First stage feeds only the second stage
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      prev_reg <= 1'b0;
    end else begin
      meta_reg <= pin_in;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  assign level = sync_reg;
  assign rise = sync_reg & ~prev_reg;
endmodule // pin_sync_edge

// >>> shared/enc_cmp_pkg.sv
// Register map, field layout and types of the encoder compare counter
package enc_cmp_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int STRB_W = DATA_W / 8;
  localparam int CNT_W = 24;
  localparam int LOW_W = 16;
  localparam int CTRL_W = 7;
  localparam int STAT_W = 2;
  localparam int PIN_N = 3;
  localparam logic [ADDR_W-1:0] CTRL_OFS = 8'h00;
  localparam logic [ADDR_W-1:0] STAT_OFS = 8'h04;
  localparam logic [ADDR_W-1:0] MASK_OFS = 8'h08;
  localparam logic [ADDR_W-1:0] CMPV_OFS = 8'h0C;
  localparam logic [ADDR_W-1:0] CNT_OFS = 8'h10;
  localparam int STAT_CMP = 0;
  localparam int STAT_ZDET = 1;
  localparam int PIN_PULSE = 0;
  localparam int PIN_DIR = 1;
  localparam int PIN_Z = 2;
  localparam logic [1:0] MODE_ENCODER = 2'h0;
  localparam logic [1:0] MODE_EVENT = 2'h1;
  localparam logic [1:0] MODE_TIMECNT = 2'h2;
  localparam logic [1:0] MODE_TIMER = 2'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [CNT_W-1:0] CNT_RESET = 24'h000000;
  localparam logic [CNT_W-1:0] CMPV_RESET = 24'h000000;
  localparam logic [LOW_W-1:0] LOW_STEP = 16'h0001;
  localparam logic [CNT_W-1:0] CNT_STEP = 24'h000001;
  localparam logic [STAT_W-1:0] STAT_RESET = 2'h0;

  // Control register, bit 0 is run, bit 6 is interrupt enable
  typedef struct packed {
    logic inten;
    logic cmpen;
    logic three_phase_enable;
    logic zen;
    logic [1:0] mode;
    logic run;
  } ctrl_t;

  typedef struct packed {
    logic z;
    logic dir;
    logic pulse;
  } pin_t;

  typedef enum {
    OP_ENC, OP_ENC_Z, OP_EVT2, OP_EVT3,
    OP_TCNT2, OP_TCNT3, OP_TMR, OP_TMR_Z
  } op_mode_t;
endpackage

// >>> sim/enc_pin_model.sv
// Behavioural encoder pin source: pulse train then optional Z mark
`timescale 1ns/1ps
module enc_pin_model
  import enc_cmp_pkg::*;
(
  // Clock
  input wire logic aclk,
  // Commands from the bench
  input wire logic go,
  input wire logic [7:0] n_pulse,
  input wire logic dir_up,
  input wire logic z_mark,
  // Pins and status
  output pin_t pins,
  output logic busy
);
  // Four-cycle phases so every edge clears the two-stage synchroniser
  initial begin
    pins = '0;
    busy = 1'b0;
    forever begin
      @(posedge aclk);
      while (!go) @(posedge aclk);
      busy <= 1'b1;
      pins.dir <= dir_up;
      repeat (n_pulse) begin
        repeat (4) @(posedge aclk);
        pins.pulse <= 1'b1;
        repeat (4) @(posedge aclk);
        pins.pulse <= 1'b0;
      end
      if (z_mark) begin
        repeat (4) @(posedge aclk);
        pins.z <= 1'b1;
        repeat (4) @(posedge aclk);
        pins.z <= 1'b0;
      end
      repeat (2) @(posedge aclk);
      busy <= 1'b0;
    end
  end
endmodule // enc_pin_model

// >>> sim/tb_encoder_compare_counter.sv
// Self-checking bench for the encoder compare counter
`timescale 1ns/1ps
module tb_encoder_compare_counter
  import enc_cmp_pkg::*;
;
  logic aclk = 0, aresetn = 0;
  logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
  logic [DATA_W-1:0] wdata = '0, rdata;
  logic [STRB_W-1:0] wstrb = '0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, enc_req, irq;
  logic [1:0] bresp, rresp;
  logic [1:0] b_last;
  logic go = 0, dir_up = 1, z_mark = 0, busy;
  logic [7:0] n_pulse = '0;
  pin_t pins;
  int err_total = 0, check_count = 0;

  encoder_compare_counter dut (.aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .enc_pins(pins), .encoder_irq_request(enc_req),
    .irq(irq));

  enc_pin_model far_end (.aclk(aclk), .go(go), .n_pulse(n_pulse),
    .dir_up(dir_up), .z_mark(z_mark), .pins(pins), .busy(busy));

  initial begin
    forever #10 aclk = ~aclk;
  end

  task automatic end_of_test();
    $display("Counts: %0d checks, %0d mismatches", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    // Address and data are released independently as each is taken
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    b_last = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(d, exp);
  endtask

  // Stop clears status, so each scenario starts with a clean flag
  task automatic setup(input logic [31:0] ctl, cmp, cnt);
    wr(CTRL_OFS, 32'h00000000);
    wr(CNT_OFS, cnt);
    wr(CMPV_OFS, cmp);
    wr(MASK_OFS, 32'h00000001);
    wr(CTRL_OFS, ctl);
  endtask

  task automatic pulses(input logic [7:0] n, input logic z);
    @(posedge aclk);
    n_pulse <= n;
    z_mark <= z;
    go <= 1'b1;
    @(posedge aclk);
    go <= 1'b0;
    @(posedge aclk);
    while (busy) @(posedge aclk);
    repeat (8) @(posedge aclk);
  endtask

  task automatic t_regs();
    logic [31:0] d;
    logic [1:0] r;
    rd_chk(CMPV_OFS, 32'h00000000);
    rd_chk(CNT_OFS, 32'h00000000);
    rd(8'h14, d, r);
    chk({30'h0, r}, {30'h0, RESP_SLVERR});
    wr(8'h14, 32'h00000000);
    chk({30'h0, b_last}, {30'h0, RESP_SLVERR});
    wr(CMPV_OFS, 32'hFFFFFFFF);
    chk({30'h0, b_last}, {30'h0, RESP_OKAY});
    rd_chk(CMPV_OFS, 32'h00FFFFFF);
    wr(CNT_OFS, 32'hAB123456);
    rd_chk(CNT_OFS, 32'h00123456);
    $display("test regs done");
  endtask

  task automatic t_encoder();
    setup(32'h00000061, 32'h00FF0003, 32'h0);
    pulses(8'h02, 1'b0);
    rd_chk(STAT_OFS, 32'h00000000);
    pulses(8'h01, 1'b0);
    rd_chk(STAT_OFS, 32'h00000001);
    chk({31'h0, enc_req}, 32'h1);
    chk({31'h0, irq}, 32'h1);
    // Interrupt enable off: flag alone, no request
    setup(32'h00000021, 32'h00000002, 32'h0);
    pulses(8'h02, 1'b0);
    rd_chk(STAT_OFS, 32'h00000001);
    chk({31'h0, enc_req}, 32'h0);
    wr(STAT_OFS, 32'h00000001);
    rd_chk(STAT_OFS, 32'h00000000);
    chk({31'h0, irq}, 32'h0);
    // Counting down from five reaches three after two pulses
    dir_up <= 1'b0;
    setup(32'h00000021, 32'h00000003, 32'h00000005);
    pulses(8'h02, 1'b0);
    rd_chk(STAT_OFS, 32'h00000001);
    rd_chk(CNT_OFS, 32'h00000003);
    dir_up <= 1'b1;
    $display("test encoder done");
  endtask

  task automatic t_zgate();
    setup(32'h00000069, 32'h00000002, 32'h0);
    pulses(8'h02, 1'b0);
    rd_chk(STAT_OFS, 32'h00000001);
    chk({31'h0, enc_req}, 32'h0);
    pulses(8'h00, 1'b1);
    rd_chk(STAT_OFS, 32'h00000003);
    chk({31'h0, enc_req}, 32'h1);
    // Event count, three phase, Z enable set but without effect
    setup(32'h0000007B, 32'h00AA0004, 32'h0);
    pulses(8'h04, 1'b0);
    rd_chk(STAT_OFS, 32'h00000001);
    chk({31'h0, enc_req}, 32'h1);
    $display("test z gate done");
  endtask

  task automatic t_timers();
    logic [31:0] d;
    logic [1:0] r;
    // Low 16 bits alone would match after five clocks
    setup(32'h00000067, 32'h00010005, 32'h0);
    repeat (40) @(posedge aclk);
    rd_chk(STAT_OFS, 32'h00000000);
    wr(CNT_OFS, 32'h0000FFF0);
    repeat (40) @(posedge aclk);
    rd_chk(STAT_OFS, 32'h00000001);
    chk({31'h0, enc_req}, 32'h1);
    setup(32'h00000065, 32'h00000030, 32'h0);
    repeat (80) @(posedge aclk);
    rd_chk(STAT_OFS, 32'h00000001);
    chk({31'h0, enc_req}, 32'h1);
    // Timer with Z: a Z mark restarts the count, far from its old value
    setup(32'h0000006F, 32'h00FFFFFF, 32'h0);
    repeat (200) @(posedge aclk);
    pulses(8'h00, 1'b1);
    rd_chk(STAT_OFS, 32'h00000002);
    rd(CNT_OFS, d, r);
    chk({31'h0, (d < 32'h00000040)}, 32'h1);
    $display("test timers done");
  endtask

  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_encoder();
    t_zgate();
    t_timers();
    end_of_test();
  end

  // Whole run needs under a thousand cycles; this allows ample margin
  initial begin
    repeat (20000) @(posedge aclk);
    err_total++;
    end_of_test();
  end
endmodule // tb_encoder_compare_counter
